// ---- shared/icu_cfg.svh ----
// Offsets, field positions, reset values and timing counts of the internal clock unit.
`ifndef ICU_CFG_SVH
`define ICU_CFG_SVH
`define ICU_ADDR_CTRL_ONE   2'h0
`define ICU_ADDR_CTRL_TWO   2'h1
`define ICU_ADDR_COARSE     2'h2
`define ICU_ADDR_STATE      2'h3
`define ICU_SEL_HI          7
`define ICU_SEL_LO          6
`define ICU_KEEPALIVE_BIT   0
`define ICU_DIV_HI          7
`define ICU_DIV_LO          6
`define ICU_LOOP_OFF_BIT    3
`define ICU_STATE_HI        3
`define ICU_STATE_LO        2
`define ICU_FINE_BIT        0
`define ICU_SEL_RST         2'h0
`define ICU_DIV_RST         2'h0
`define ICU_COARSE_POR      8'h80
`define ICU_STATE_LOOP      2'h0
`define ICU_STATE_REF       2'h1
`define ICU_NCO_BASE        10'h100
`define ICU_LOOP_SHIFT      9
`define ICU_CLK_KHZ         20000
`define ICU_ACQ_US          1000
`endif

// ---- shared/icu_pkg.sv ----
// Types shared by the internal clock unit: register port bundle and clock modes.
package icu_pkg;
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} icu_bus_req_t;
	typedef enum logic [2:0] {
		ICU_LOOP_ENGAGED       = 3'h1,
		ICU_LOOP_BYPASSED      = 3'h2,
		ICU_BYPASSED_LOW_POWER = 3'h4
	} icu_mode_t;
endpackage

// ---- hdl/icu_top.sv ----
// Internal clock unit: source mode control, reference and loop tick models, bus divider.
//
// Function
// - Reset brings up loop engaged mode.
// - Cleared source select enters loop engaged mode.
// - Engaged bus rate is reference times 512 divided.
// - Select set, loop-off clear: bypassed mode.
// - Bypassed bus rate is reference divided.
// - Bypassed mode keeps loop running, unused.
// - Select and loop-off set: low power bypass.
// - Low power bypass stops the loop.
// - Loop-off bit gates the loop in bypass.
// - Read-only field shows the active source.
// - Keepalive bit keeps reference alive in stop.
// - Divider acts on the selected source clock.
// - Coarse adjust sets reference frequency.
// - Fine bit gives smallest reference step.
// - Divider changes take effect immediately.
// - Adjust values survive ordinary reset.
//
// Local design decisions: the register offsets and the plain strobed port.
`include "icu_cfg.svh"
`timescale 1ns/1ns
`default_nettype none

module icu_top #(
	parameter int unsigned ACQ_CYC = `ICU_ACQ_US * `ICU_CLK_KHZ / 1000
) (
	input  wire logic                 ref_clk,
	input  wire logic                 reset,
	input  wire logic                 power_on,
	input  wire logic                 clk_en,
	input  wire icu_pkg::icu_bus_req_t bus,
	input  wire logic                 stop_req,
	output logic [7:0]                rdata,
	output logic                      bus_tick,
	output logic                      ref_run,
	output logic                      loop_run,
	output logic                      loop_locked
);

	logic [1:0]         source_select_r;
	logic               ref_stop_keepalive_r;
	logic [1:0]         bus_divider_select_r;
	logic               loop_off_in_bypass_r;
	logic [7:0]         coarse_adjust_r;
	logic               fine_ref_adjust_r;
	logic [7:0]         rdata_r;
	logic [19:0]        ref_acc_r;
	logic [19:0]        loop_acc_r;
	logic               ref_tick_r;
	logic               loop_tick_r;
	logic               ref_run_r;
	logic               loop_run_r;
	logic [15:0]        lock_cnt_r;
	logic               locked_r;
	logic [3:0]         div_cnt_r;
	logic               bus_tick_r;
	icu_pkg::icu_mode_t mode_r;
	icu_pkg::icu_mode_t mode_nxt;
	icu_pkg::icu_mode_t target_mode;
	logic [9:0]         ref_inc;
	logic [20:0]        ref_sum;
	logic [20:0]        loop_sum;
	logic               src_tick;
	logic [3:0]         div_mask;
	logic [1:0]         source_state;
	logic               wr_ctrl_one;
	logic               wr_ctrl_two;
	logic               wr_coarse;
	logic               wr_state;
	logic               adjust_write;
	logic               seen_r;

	// Write decodes; every address of the two-bit space is mapped.
	assign wr_ctrl_one  = bus.wr && (bus.addr == `ICU_ADDR_CTRL_ONE);
	assign wr_ctrl_two  = bus.wr && (bus.addr == `ICU_ADDR_CTRL_TWO);
	assign wr_coarse    = bus.wr && (bus.addr == `ICU_ADDR_COARSE);
	assign wr_state     = bus.wr && (bus.addr == `ICU_ADDR_STATE);
	assign adjust_write = wr_coarse || wr_state;

	// Control registers return to the engaged configuration on reset; power_on alone does not clear them.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			source_select_r      <= `ICU_SEL_RST;
			ref_stop_keepalive_r <= 1'b0;
			bus_divider_select_r <= `ICU_DIV_RST;
			loop_off_in_bypass_r <= 1'b0;
		end else if (clk_en) begin
			if (wr_ctrl_one) begin
				source_select_r      <= bus.wdata[`ICU_SEL_HI:`ICU_SEL_LO];
				ref_stop_keepalive_r <= bus.wdata[`ICU_KEEPALIVE_BIT];
			end
			if (wr_ctrl_two) begin
				bus_divider_select_r <= bus.wdata[`ICU_DIV_HI:`ICU_DIV_LO];
				loop_off_in_bypass_r <= bus.wdata[`ICU_LOOP_OFF_BIT];
			end
		end
	end

	// Adjust values clear only at power-on, so a system reset keeps the tuning.
	// survives ordinary reset
	always_ff @(posedge ref_clk or posedge power_on) begin
		if (power_on) begin
			coarse_adjust_r   <= `ICU_COARSE_POR;
			fine_ref_adjust_r <= 1'b0;
		end else if (clk_en) begin
			if (wr_coarse) begin
				coarse_adjust_r <= bus.wdata;
			end
			if (wr_state) begin
				fine_ref_adjust_r <= bus.wdata[`ICU_FINE_BIT];
			end
		end
	end

	// Read port: data stands in the cycle after the strobe, zero otherwise.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			rdata_r <= 8'h00;
		end else if (clk_en) begin
			rdata_r <= 8'h00;
			if (bus.rd) begin
				case (bus.addr)
					`ICU_ADDR_CTRL_ONE: begin
						rdata_r[`ICU_SEL_HI:`ICU_SEL_LO] <= source_select_r;
						rdata_r[`ICU_KEEPALIVE_BIT]      <= ref_stop_keepalive_r;
					end
					`ICU_ADDR_CTRL_TWO: begin
						rdata_r[`ICU_DIV_HI:`ICU_DIV_LO] <= bus_divider_select_r;
						rdata_r[`ICU_LOOP_OFF_BIT]       <= loop_off_in_bypass_r;
					end
					`ICU_ADDR_COARSE: begin
						rdata_r <= coarse_adjust_r;
					end
					`ICU_ADDR_STATE: begin
						rdata_r[`ICU_STATE_HI:`ICU_STATE_LO] <= source_state;
						rdata_r[`ICU_FINE_BIT]               <= fine_ref_adjust_r;
					end
					default: begin
						rdata_r <= 8'h00;
					end
				endcase
			end
		end
	end
	assign rdata = rdata_r;

	// Requested mode from the select field and the loop-off bit.
	// mode decode
	always_comb begin
		if (source_select_r == `ICU_SEL_RST) begin
			target_mode = icu_pkg::ICU_LOOP_ENGAGED;
		end else if (loop_off_in_bypass_r) begin
			target_mode = icu_pkg::ICU_BYPASSED_LOW_POWER;
		end else begin
			target_mode = icu_pkg::ICU_LOOP_BYPASSED;
		end
	end

	// Run enables, registered so the oscillators start on a clean edge.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ref_run_r  <= 1'b1;
			loop_run_r <= 1'b1;
		end else if (clk_en) begin
			ref_run_r  <= !(stop_req && !ref_stop_keepalive_r);
			loop_run_r <= !(stop_req && !ref_stop_keepalive_r)
				&& (target_mode != icu_pkg::ICU_BYPASSED_LOW_POWER);
		end
	end
	assign ref_run  = ref_run_r;
	assign loop_run = loop_run_r;

	// The reference step grows with the adjust value; the base keeps it from stalling.
	// coarse and fine step
	assign ref_inc  = {1'b0, coarse_adjust_r, fine_ref_adjust_r} + `ICU_NCO_BASE;
	assign ref_sum  = {1'b0, ref_acc_r} + 21'(ref_inc);
	assign loop_sum = {1'b0, loop_acc_r} + 21'({ref_inc, {`ICU_LOOP_SHIFT{1'b0}}});

	// Reference tick model: phase accumulator overflow.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			ref_acc_r  <= 20'h00000;
			ref_tick_r <= 1'b0;
		end else if (clk_en) begin
			ref_tick_r <= ref_run_r && ref_sum[20];
			if (ref_run_r) begin
				ref_acc_r <= ref_sum[19:0];
			end
		end
	end

	// Loop tick model; a stopped loop holds its phase and ticks no more.
	// loop keeps running in bypass unless loop-off is set
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			loop_acc_r  <= 20'h00000;
			loop_tick_r <= 1'b0;
		end else if (clk_en) begin
			loop_tick_r <= loop_run_r && loop_sum[20];
			if (loop_run_r) begin
				loop_acc_r <= loop_sum[19:0];
			end
		end
	end

	// Acquisition counter restarts whenever the loop stops or the adjust changes.
	// lock indication for software
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			lock_cnt_r <= 16'h0000;
			locked_r   <= 1'b0;
		end else if (clk_en) begin
			if (!loop_run_r || adjust_write) begin
				lock_cnt_r <= 16'h0000;
				locked_r   <= 1'b0;
			end else if (lock_cnt_r != 16'(ACQ_CYC)) begin
				lock_cnt_r <= lock_cnt_r + 16'h0001;
			end else begin
				locked_r <= 1'b1;
			end
		end
	end
	assign loop_locked = locked_r;

	// Mode switching waits for a tick of the new source, trading a short stall for
	// a clean handover; the two bypass modes share a source and change at once.
	// switch completes first
	always_comb begin
		mode_nxt = mode_r;
		case (mode_r)
			icu_pkg::ICU_LOOP_ENGAGED: begin
				if ((target_mode != icu_pkg::ICU_LOOP_ENGAGED) && ref_tick_r) begin
					mode_nxt = target_mode;
				end
			end
			icu_pkg::ICU_LOOP_BYPASSED, icu_pkg::ICU_BYPASSED_LOW_POWER: begin
				if (target_mode == icu_pkg::ICU_LOOP_ENGAGED) begin
					if (loop_tick_r) begin
						mode_nxt = icu_pkg::ICU_LOOP_ENGAGED;
					end
				end else begin
					mode_nxt = target_mode;
				end
			end
			default: begin
				mode_nxt = icu_pkg::ICU_LOOP_ENGAGED;
			end
		endcase
	end

	// Mode register.
	// engaged after reset
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			mode_r <= icu_pkg::ICU_LOOP_ENGAGED;
		end else if (clk_en) begin
			mode_r <= mode_nxt;
		end
	end

	assign source_state = (mode_r == icu_pkg::ICU_LOOP_ENGAGED)
		? `ICU_STATE_LOOP : `ICU_STATE_REF;

	assign src_tick = (mode_r == icu_pkg::ICU_LOOP_ENGAGED) ? loop_tick_r : ref_tick_r;
	assign div_mask = 4'((5'h02 << bus_divider_select_r) - 5'h01);

	// Bus divider by two to the power of field plus one.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			div_cnt_r  <= 4'h0;
			bus_tick_r <= 1'b0;
		end else if (clk_en) begin
			bus_tick_r <= src_tick && ((div_cnt_r & div_mask) == div_mask);
			if (src_tick) begin
				div_cnt_r <= div_cnt_r + 4'h1;
			end
		end
	end
	assign bus_tick = bus_tick_r;

	// Helper for checks: low until the first enabled edge after reset.
	always_ff @(posedge ref_clk or posedge reset) begin
		if (reset) begin
			seen_r <= 1'b0;
		end else if (clk_en) begin
			seen_r <= 1'b1;
		end
	end

	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (reset || !clk_en);

	property p_reset_mode;
		!seen_r |-> (mode_r == icu_pkg::ICU_LOOP_ENGAGED) && ref_run_r;
	endproperty
	a_reset_mode: assert property (p_reset_mode) else $error("not engaged after reset");

	property p_enter_engaged;
		(target_mode == icu_pkg::ICU_LOOP_ENGAGED) && loop_tick_r
			|=> (mode_r == icu_pkg::ICU_LOOP_ENGAGED);
	endproperty
	a_enter_engaged: assert property (p_enter_engaged) else $error("engage missed");

	property p_engaged_source;
		(mode_r == icu_pkg::ICU_LOOP_ENGAGED) |-> (src_tick == loop_tick_r);
	endproperty
	a_engaged_source: assert property (p_engaged_source) else $error("wrong engaged source");

	property p_bypass_source;
		(mode_r != icu_pkg::ICU_LOOP_ENGAGED) |-> (src_tick == ref_tick_r);
	endproperty
	a_bypass_source: assert property (p_bypass_source) else $error("wrong bypass source");

	property p_bypass_loop_on;
		(mode_r == icu_pkg::ICU_LOOP_BYPASSED) && ref_run_r && !stop_req
			&& (target_mode == icu_pkg::ICU_LOOP_BYPASSED) |=> loop_run_r;
	endproperty
	a_bypass_loop_on: assert property (p_bypass_loop_on) else $error("loop stopped in bypass");

	property p_low_power_off;
		(target_mode == icu_pkg::ICU_BYPASSED_LOW_POWER) |=> !loop_run_r ##1 !loop_tick_r;
	endproperty
	a_low_power_off: assert property (p_low_power_off) else $error("loop alive in low power");

	property p_status_read;
		bus.rd && (bus.addr == `ICU_ADDR_STATE)
			|=> rdata[`ICU_STATE_HI:`ICU_STATE_LO] == $past(source_state);
	endproperty
	a_status_read: assert property (p_status_read) else $error("bad source state read");

	property p_stop_ref;
		stop_req && !ref_stop_keepalive_r |=> !ref_run_r ##1 !ref_tick_r;
	endproperty
	a_stop_ref: assert property (p_stop_ref) else $error("reference ran in stop");

	property p_divider;
		src_tick && ((div_cnt_r & div_mask) == div_mask) |=> bus_tick_r;
	endproperty
	a_divider: assert property (p_divider) else $error("divider tick missed");

	property p_bus_cause;
		bus_tick_r |-> $past(src_tick);
	endproperty
	a_bus_cause: assert property (p_bus_cause) else $error("bus tick without source");

	property p_switch_done;
		(mode_r == icu_pkg::ICU_LOOP_ENGAGED) && ($past(mode_r) != icu_pkg::ICU_LOOP_ENGAGED)
			|-> $past(loop_tick_r);
	endproperty
	a_switch_done: assert property (p_switch_done) else $error("engaged before loop tick");

endmodule

`default_nettype wire

// ---- sim/icu_top_tb_top.sv ----
// Self-checking testbench of the internal clock unit.
`timescale 1ns/1ns
`default_nettype none

module icu_top_tb_top;
	typedef struct packed {
		logic [1:0] addr;
		logic [7:0] wdata;
		logic [7:0] exp;
	} icu_row_t;
	logic                  ref_clk;
	logic                  reset;
	logic                  power_on;
	logic                  clk_en;
	logic                  stop_req;
	icu_pkg::icu_bus_req_t bus;
	logic [7:0]            rdata;
	logic                  bus_tick;
	logic                  ref_run;
	logic                  loop_run;
	logic                  loop_locked;
	int                    error_cnt;
	int                    checks;
	icu_row_t              rows [9];

	// A short lock count keeps the acquisition wait inside a quick run.
	icu_top #(.ACQ_CYC(20)) i_dut (
		.ref_clk     (ref_clk),
		.reset       (reset),
		.power_on    (power_on),
		.clk_en      (clk_en),
		.bus         (bus),
		.stop_req    (stop_req),
		.rdata       (rdata),
		.bus_tick    (bus_tick),
		.ref_run     (ref_run),
		.loop_run    (loop_run),
		.loop_locked (loop_locked)
	);

	// Free-running 20 MHz clock.
	always #25 ref_clk = ~ref_clk;

	task automatic bad(input string msg);
		error_cnt++;
		$display("unexpected at %0t: %s", $time, msg);
	endtask

	task automatic chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
		checks++;
		if (got !== exp)
			bad(msg);
	endtask

	task automatic wr(input logic [1:0] a, input logic [7:0] d);
		@(posedge ref_clk);
		bus.addr <= a;
		bus.wdata <= d;
		bus.wr <= 1'b1;
		@(posedge ref_clk);
		bus.wr <= 1'b0;
	endtask

	// Read data are sampled in the one cycle where they stand.
	task automatic rd(input logic [1:0] a, input logic [7:0] exp, input string msg);
		@(posedge ref_clk);
		bus.addr <= a;
		bus.rd <= 1'b1;
		@(posedge ref_clk);
		bus.rd <= 1'b0;
		#1;
		chk(rdata, exp, msg);
	endtask

	// Counts bus ticks over a window; the 4096-cycle power-of-two window makes the count exact.
	task automatic cnt(input int n, input int exp);
		int c;
		c = 0;
		repeat (n) begin
			@(posedge ref_clk);
			#1;
			if (bus_tick === 1'b1)
				c++;
		end
		checks++;
		if (c != exp)
			bad("bus tick count");
	endtask

	task automatic final_report;
		$display("checks %0d, mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Watchdog cuts a hang short well after the expected run of about 33000 cycles.
	initial begin
		#3000000;
		error_cnt++;
		final_report();
	end

	// Main sequence: reset, register rows, then rates, modes, stop and clock enable.
	initial begin
		ref_clk = 1'b0;
		reset = 1'b1;
		power_on = 1'b1;
		clk_en = 1'b1;
		stop_req = 1'b0;
		bus = '0;
		error_cnt = 0;
		checks = 0;
		rows = '{'{2'h1, 8'hff, 8'hc8}, '{2'h1, 8'h00, 8'h00}, '{2'h2, 8'h5a, 8'h5a},
			'{2'h2, 8'h80, 8'h80}, '{2'h3, 8'hff, 8'h01}, '{2'h3, 8'h00, 8'h00},
			'{2'h0, 8'h3e, 8'h00}, '{2'h0, 8'h01, 8'h01}, '{2'h0, 8'h00, 8'h00}};
		repeat (6) @(posedge ref_clk);
		reset <= 1'b0;
		power_on <= 1'b0;
		rd(2'h0, 8'h00, "ctrl one reset");
		rd(2'h1, 8'h00, "ctrl two reset");
		rd(2'h2, 8'h80, "coarse reset");
		rd(2'h3, 8'h00, "state reset");
		$display("test reset done");
		foreach (rows[i]) begin
			wr(rows[i].addr, rows[i].wdata);
			rd(rows[i].addr, rows[i].exp, "register row");
		end
		$display("test registers done");
		cnt(4096, 512);
		wr(2'h1, 8'hc0);
		cnt(4096, 64);
		wr(2'h1, 8'h00);
		wr(2'h3, 8'h01);
		cnt(4096, 513);
		wr(2'h3, 8'h00);
		wr(2'h2, 8'h00);
		cnt(4096, 256);
		wr(2'h2, 8'h80);
		@(posedge ref_clk);
		#1;
		chk({7'h0, loop_locked}, 8'h00, "lock after adjust");
		repeat (25) @(posedge ref_clk);
		chk({7'h0, loop_locked}, 8'h01, "lock regained");
		$display("test engaged rates done");
		wr(2'h0, 8'h40);
		rd(2'h3, 8'h00, "state before switch");
		repeat (2100) @(posedge ref_clk);
		rd(2'h3, 8'h04, "state bypassed");
		chk({7'h0, loop_run}, 8'h01, "loop kept in bypass");
		cnt(4096, 1);
		wr(2'h1, 8'h08);
		repeat (3) @(posedge ref_clk);
		chk({6'h0, ref_run, loop_run}, 8'h02, "low power run flags");
		rd(2'h3, 8'h04, "state low power");
		cnt(4096, 1);
		wr(2'h1, 8'h00);
		repeat (3) @(posedge ref_clk);
		chk({7'h0, loop_run}, 8'h01, "loop restarted");
		wr(2'h0, 8'h00);
		repeat (8) @(posedge ref_clk);
		rd(2'h3, 8'h00, "state engaged again");
		$display("test modes done");
		wr(2'h2, 8'h33);
		wr(2'h0, 8'h40);
		repeat (2100) @(posedge ref_clk);
		reset <= 1'b1;
		repeat (2) @(posedge ref_clk);
		reset <= 1'b0;
		rd(2'h3, 8'h00, "state after reset");
		rd(2'h0, 8'h00, "ctrl after reset");
		rd(2'h2, 8'h33, "coarse kept");
		wr(2'h2, 8'h80);
		cnt(4096, 512);
		$display("test second reset done");
		stop_req <= 1'b1;
		repeat (3) @(posedge ref_clk);
		chk({6'h0, ref_run, loop_run}, 8'h00, "stop without keepalive");
		wr(2'h0, 8'h01);
		repeat (3) @(posedge ref_clk);
		chk({6'h0, ref_run, loop_run}, 8'h03, "stop with keepalive");
		stop_req <= 1'b0;
		wr(2'h0, 8'h00);
		$display("test stop done");
		// A write while the clock enable is low must be ignored.
		clk_en <= 1'b0;
		wr(2'h2, 8'h11);
		clk_en <= 1'b1;
		rd(2'h2, 8'h80, "write while frozen");
		$display("test clock enable done");
		final_report();
	end
endmodule

`default_nettype wire
